// >>> hdl/sarcf_params.svh
`ifndef SARCF_PARAMS_SVH
`define SARCF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (special-function-register addresses)
// ----------------------------------------------------------------------
`define SARCF_OFS_CONFIG   8'hBC
`define SARCF_OFS_RES_LO   8'hBD
`define SARCF_OFS_RES_HI   8'hBE

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define SARCF_DIV_MSB      7
`define SARCF_DIV_LSB      3
`define SARCF_JUSTIFY_BIT  2
`define SARCF_RES_BIT      1
`define SARCF_GAIN_BIT     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SARCF_CONFIG_RST   8'hF8
`define SARCF_RESULT_RST   8'h00

// ----------------------------------------------------------------------
// Timing counts, in conversion-clock cycles
// ----------------------------------------------------------------------
`define SARCF_CYC_10BIT    4'hA
`define SARCF_CYC_8BIT     4'h8

`endif

// >>> hdl/sarcf_pkg.sv
package sarcf_pkg;

	// Configuration register layout
	typedef struct packed {
		logic [4:0] clock_divider;
		logic       justify_select;
		logic       resolution_select;
		logic       gain_select;
	} sarcf_config_t;

	// Formatted result pair
	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} sarcf_result_t;

	// Special-function-register access strobe group
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sarcf_sfr_req_t;

	// Conversion sequencer states, Gray ordered
	typedef enum logic [1:0] {
		SARCF_IDLE    = 2'b00,
		SARCF_CONVERT = 2'b01,
		SARCF_FINISH  = 2'b11
	} sarcf_state_t;

endpackage : sarcf_pkg

// >>> hdl/sarcf_clock_divider.sv
`timescale 1ns/1ps

// Conversion clock enable: one pulse every (divider + 1) system clocks
module sarcf_clock_divider #(
	parameter int DIV_W = 5
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// Control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divider,
	// Enable out
	output logic                  conv_clk_en
);

	logic [DIV_W-1:0] count_r;

	// ------------------------------------------------------------------
	// Divider counter
	// ------------------------------------------------------------------
	// Restarts when idle so each conversion begins with a full period
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= '0;
		end else if (!run || count_r == divider) begin
			count_r <= '0;
		end else begin
			count_r <= count_r + 1'b1;
		end
	end

	// Pulse on terminal count gives rate system_clock/(divider+1)
	assign conv_clk_en = run && (count_r == divider);

endmodule : sarcf_clock_divider

// >>> hdl/sarcf_core.sv
`timescale 1ns/1ps
`include "sarcf_params.svh"

// Notes on behaviour
// - Conversion clock equals system clock over divider+1
// - Justify bit picks right or left placement
// - Justify bit ignored in 8-bit resolution
// - Resolution bit: 0 ten-bit, 1 eight-bit
// - Gain bit: 0 half gain, 1 unity
// - Right justified: high byte zeros, two MSBs
// - Left justified: high byte holds eight MSBs
// - Eight-bit mode: high byte holds whole result
// - Right justified: low byte holds eight LSBs
// - Left justified: low bits 7:6 LSBs, rest zero
// - Eight-bit mode: low byte reads zero
// - Result bytes load at conversion end
// - Eight-bit conversion two conversion clocks shorter
module sarcf_core #(
	parameter int CODE_W = 10,
	parameter int DIV_W  = 5
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	// Special-function-register access
	input  sarcf_pkg::sarcf_sfr_req_t  sfr_req,
	output logic [7:0]                 sfr_rdata,
	output logic                       sfr_hit,
	// Converter core side
	input  wire logic                  conv_start,
	input  wire logic [CODE_W-1:0]     conv_code,
	output logic                       conv_clk_en,
	output logic                       conv_busy,
	output logic                       conv_done,
	output logic                       gain_unity,
	output logic                       eight_bit_active
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	sarcf_pkg::sarcf_config_t config_r;
	sarcf_pkg::sarcf_config_t job_cfg_r;
	sarcf_pkg::sarcf_state_t  state_r;
	logic [7:0]               result_hi_r;
	logic [7:0]               result_lo_r;
	logic [3:0]               bit_cnt_r;
	logic [7:0]               rdata_r;
	logic                     done_r;
	logic                     run;
	logic                     last_bit;
	logic                     wr_cfg;
	logic                     wr_lo;
	logic                     wr_hi;
	sarcf_pkg::sarcf_result_t fmt;

	// Map a finished code into the two result bytes
	function automatic sarcf_pkg::sarcf_result_t format_code(
		input logic [CODE_W-1:0] code,
		input logic              justify,
		input logic              eight_bit
	);
		sarcf_pkg::sarcf_result_t r;
		r = '0;
		if (eight_bit) begin
			r.high_byte = code[CODE_W-1 -: 8];
			r.low_byte  = 8'h00;
		end else if (justify) begin
			r.high_byte = code[CODE_W-1 -: 8];
			r.low_byte  = {code[1:0], 6'h00};
		end else begin
			r.high_byte = {6'h00, code[CODE_W-1 -: 2]};
			r.low_byte  = code[7:0];
		end
		return r;
	endfunction : format_code

	// Address decode shared by write and read paths
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : addr_is

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	assign wr_cfg = sfr_req.wr_en && addr_is(sfr_req.addr, `SARCF_OFS_CONFIG);
	assign wr_lo  = sfr_req.wr_en && addr_is(sfr_req.addr, `SARCF_OFS_RES_LO);
	assign wr_hi  = sfr_req.wr_en && addr_is(sfr_req.addr, `SARCF_OFS_RES_HI);

	// Configuration register; fields packed in documented bit order
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_r <= sarcf_pkg::sarcf_config_t'(`SARCF_CONFIG_RST);
		end else if (wr_cfg) begin
			config_r <= sarcf_pkg::sarcf_config_t'(sfr_req.wdata);
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	// Snapshot of settings taken at start; later divider, justify and resolution writes wait for next job
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			job_cfg_r <= sarcf_pkg::sarcf_config_t'(`SARCF_CONFIG_RST);
		end else if (state_r == sarcf_pkg::SARCF_IDLE && conv_start) begin
			job_cfg_r <= config_r;
		end
	end

	assign run      = (state_r == sarcf_pkg::SARCF_CONVERT);
	// Eight-bit jobs stop two conversion clocks early
	assign last_bit = job_cfg_r.resolution_select ?
		(bit_cnt_r == `SARCF_CYC_8BIT) : (bit_cnt_r == `SARCF_CYC_10BIT);

	// State register; a start while busy is ignored
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= sarcf_pkg::SARCF_IDLE;
		end else begin
			unique case (state_r)
				sarcf_pkg::SARCF_IDLE: begin
					if (conv_start) begin
						state_r <= sarcf_pkg::SARCF_CONVERT;
					end
				end
				sarcf_pkg::SARCF_CONVERT: begin
					if (conv_clk_en && last_bit) begin
						state_r <= sarcf_pkg::SARCF_FINISH;
					end
				end
				sarcf_pkg::SARCF_FINISH: begin
					state_r <= sarcf_pkg::SARCF_IDLE;
				end
				default: begin
					state_r <= sarcf_pkg::SARCF_IDLE;
				end
			endcase
		end
	end

	// Bit counter advances on each conversion-clock enable
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_r <= 4'h1;
		end else if (!run) begin
			bit_cnt_r <= 4'h1;
		end else if (conv_clk_en) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	sarcf_clock_divider #(
		.DIV_W (DIV_W)
	) u_div (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.run         (run),
		.divider     (job_cfg_r.clock_divider),
		.conv_clk_en (conv_clk_en)
	);

	// ------------------------------------------------------------------
	// Result bytes
	// ------------------------------------------------------------------
	// Format uses the snapshot; justify is dropped when eight-bit is set
	assign fmt = format_code(conv_code, job_cfg_r.justify_select,
		job_cfg_r.resolution_select);

	// Hardware load wins over a same-cycle software write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_hi_r <= `SARCF_RESULT_RST;
			result_lo_r <= `SARCF_RESULT_RST;
		end else if (state_r == sarcf_pkg::SARCF_FINISH) begin
			result_hi_r <= fmt.high_byte;
			result_lo_r <= fmt.low_byte;
		end else begin
			if (wr_hi) begin
				result_hi_r <= sfr_req.wdata;
			end
			if (wr_lo) begin
				result_lo_r <= sfr_req.wdata;
			end
		end
	end

	// Completion pulse, raised at the same edge that loads the bytes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (state_r == sarcf_pkg::SARCF_FINISH);
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Registered read data; unmapped addresses read zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else if (sfr_req.rd_en) begin
			if (addr_is(sfr_req.addr, `SARCF_OFS_CONFIG)) begin
				rdata_r <= config_r;
			end else if (addr_is(sfr_req.addr, `SARCF_OFS_RES_LO)) begin
				rdata_r <= result_lo_r;
			end else if (addr_is(sfr_req.addr, `SARCF_OFS_RES_HI)) begin
				rdata_r <= result_hi_r;
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign sfr_rdata        = rdata_r;
	assign sfr_hit          = addr_is(sfr_req.addr, `SARCF_OFS_CONFIG) ||
		addr_is(sfr_req.addr, `SARCF_OFS_RES_LO) || addr_is(sfr_req.addr, `SARCF_OFS_RES_HI);
	assign conv_busy        = (state_r != sarcf_pkg::SARCF_IDLE);
	assign conv_done        = done_r;
	// Gain follows the live bit; the analog stage settles while tracking
	assign gain_unity       = config_r.gain_select;
	assign eight_bit_active = job_cfg_r.resolution_select;

endmodule : sarcf_core

// >>> tb/sarcf_core_sva.sv
`timescale 1ns/1ps
`include "sarcf_params.svh"

// ----------------------------------------------------------------------
// Port-level checker for the configuration and result formatter
// ----------------------------------------------------------------------
module sarcf_core_sva #(
	parameter int CODE_W = 10,
	parameter int DIV_W  = 5
) (
	// Clock and reset
	input wire logic                 sys_clk,
	input wire logic                 reset_n,
	// Register access
	input sarcf_pkg::sarcf_sfr_req_t sfr_req,
	input wire logic [7:0]           sfr_rdata,
	input wire logic                 sfr_hit,
	// Converter side
	input wire logic                 conv_start,
	input wire logic [CODE_W-1:0]    conv_code,
	input wire logic                 conv_clk_en,
	input wire logic                 conv_busy,
	input wire logic                 conv_done,
	input wire logic                 gain_unity,
	input wire logic                 eight_bit_active
);
	// One domain, so clock and reset are given once for all properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_enable_in_busy: assert property (conv_clk_en |-> conv_busy)
		else $error("conversion clock enable outside a conversion");
	a_done_at_end: assert property ($fell(conv_busy) |-> conv_done)
		else $error("no done pulse when busy fell");
	a_done_single: assert property (conv_done |=> !conv_done)
		else $error("done pulse longer than one cycle");
	a_done_idle: assert property (conv_done |-> !conv_busy)
		else $error("done raised while still busy");
	a_start_taken: assert property (conv_start && !conv_busy |=> conv_busy)
		else $error("idle start not taken");
	// Shortest job is eight bits at divider zero: nine busy cycles
	a_busy_min: assert property ($rose(conv_busy) |-> conv_busy [*8] ##1 conv_busy)
		else $error("conversion ended too early");
	a_gain_follow: assert property (sfr_req.wr_en && sfr_req.addr == `SARCF_OFS_CONFIG
		|=> gain_unity == $past(sfr_req.wdata[0]))
		else $error("gain output does not follow config write");
	a_mode_stable: assert property ((conv_busy ##1 conv_busy) |-> $stable(eight_bit_active))
		else $error("resolution changed inside a conversion");
endmodule : sarcf_core_sva

bind sarcf_core sarcf_core_sva #(.CODE_W(CODE_W), .DIV_W(DIV_W)) u_sva (
	.sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
	.sfr_hit(sfr_hit), .conv_start(conv_start), .conv_code(conv_code),
	.conv_clk_en(conv_clk_en), .conv_busy(conv_busy), .conv_done(conv_done),
	.gain_unity(gain_unity), .eight_bit_active(eight_bit_active)
);

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "sarcf_params.svh"

// ----------------------------------------------------------------------
// Self-checking bench: register calls and conversions
// ----------------------------------------------------------------------
module testbench;
	logic                      sys_clk;
	logic                      reset_n;
	sarcf_pkg::sarcf_sfr_req_t req;
	logic [7:0]                sfr_rdata;
	logic                      sfr_hit;
	logic                      conv_start;
	logic [9:0]                conv_code;
	logic                      conv_clk_en;
	logic                      conv_busy;
	logic                      conv_done;
	logic                      gain_unity;
	logic                      eight_bit_active;
	int                        failures;
	int                        cmp_count;
	logic [7:0]                cfgs [5] = '{8'h01, 8'h0C, 8'h13, 8'h06, 8'h05};
	logic [9:0]                codes [5] = '{10'h2A5, 10'h2A5, 10'h2A5, 10'h3FF, 10'h3FF};

	sarcf_core uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .sfr_req(req), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .conv_start(conv_start), .conv_code(conv_code),
		.conv_clk_en(conv_clk_en), .conv_busy(conv_busy), .conv_done(conv_done),
		.gain_unity(gain_unity), .eight_bit_active(eight_bit_active)
	);

	// 40 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
			if (failures == 0 && cmp_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask : print_verdict

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		begin
			cmp_count++;
			if (seen !== exp) begin
				failures++;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask : check

	// Strobes are raised at a falling edge and dropped at the next one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		begin
			req.wr_en = 1'b1;
			req.addr  = a;
			req.wdata = d;
			@(negedge sys_clk);
			req.wr_en = 1'b0;
		end
	endtask : wr

	// Read data and the decode flag are taken while the request still stands;
	// an idle cycle follows so a second read never re-raises the strobe at once
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		begin
			req.rd_en = 1'b1;
			req.addr  = a;
			@(negedge sys_clk);
			check(16'(sfr_rdata), 16'(e));
			check(16'(sfr_hit), 16'(a == `SARCF_OFS_CONFIG || a == `SARCF_OFS_RES_LO || a == `SARCF_OFS_RES_HI));
			req.rd_en = 1'b0;
			@(negedge sys_clk);
		end
	endtask : rd

	// One conversion; a refused start and a config change hit it mid-run
	task automatic run(input logic [7:0] cfg, input logic [9:0] code);
		int         n;
		int         ce;
		int         nb;
		logic [7:0] hi;
		logic [7:0] lo;
		begin
			nb = cfg[1] ? 8 : 10;
			if (cfg[1])
				{hi, lo} = {code[9:2], 8'h00};
			else if (cfg[2])
				{hi, lo} = {code[9:2], code[1:0], 6'h00};
			else
				{hi, lo} = {6'h00, code};
			wr(`SARCF_OFS_CONFIG, cfg);
			rd(`SARCF_OFS_CONFIG, cfg);
			check(16'(gain_unity), 16'(cfg[0]));
			conv_code  = code;
			conv_start = 1'b1;
			@(negedge sys_clk);
			n  = 0;
			ce = 0;
			while (conv_busy === 1'b1 && n < 400) begin
				n++;
				ce += int'(conv_clk_en);
				conv_start = (n == 2);
				if (n == 3)
					wr(`SARCF_OFS_CONFIG, cfg ^ 8'h06);
				else
					@(negedge sys_clk);
			end
			// A hung conversion counts once and skips this job's checks
			if (n >= 400) begin
				failures++;
				return;
			end
			check(16'(n), 16'(nb * (cfg[7:3] + 1) + 1));
			check(16'(ce), 16'(nb));
			check(16'(conv_done), 16'h0001);
			check(16'(eight_bit_active), 16'(cfg[1]));
			rd(`SARCF_OFS_RES_HI, hi);
			rd(`SARCF_OFS_RES_LO, lo);
		end
	endtask : run

	// Main sequence: reset values, plain access, then every format
	initial begin
		failures   = 0;
		cmp_count  = 0;
		reset_n    = 1'b0;
		req        = '0;
		conv_start = 1'b0;
		conv_code  = 10'h000;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		rd(`SARCF_OFS_CONFIG, `SARCF_CONFIG_RST);
		rd(`SARCF_OFS_RES_LO, `SARCF_RESULT_RST);
		rd(`SARCF_OFS_RES_HI, `SARCF_RESULT_RST);
		rd(8'hBF, 8'h00);
		wr(`SARCF_OFS_RES_LO, 8'h5A);
		rd(`SARCF_OFS_RES_LO, 8'h5A);
		for (int i = 0; i < 5; i++)
			run(cfgs[i], codes[i]);
		print_verdict();
	end
endmodule : testbench
